// ===== hdl/adcs_pkg.sv
package adcs_pkg;

  typedef enum logic {ADCS_EDGE_RISE, ADCS_EDGE_FALL} adcs_edge_t;
  typedef enum logic [1:0] {ADCS_CODE_UNSIGNED, ADCS_CODE_TWOS, ADCS_CODE_OFFSET} adcs_code_t;
  typedef enum logic {ADCS_READY_YES, ADCS_READY_NO} adcs_ready_t;
  typedef enum logic [1:0] {ADCS_OVF_POS, ADCS_OVF_NEG, ADCS_OVF_NONE} adcs_ovf_t;

  localparam int CLK_PERIOD_NS = 40;
  localparam int CONVERT_TIME_NS = 1000;
  localparam int SAMPLE_DELAY_NS = 200;
  localparam int MIN_RETRIGGER_NS = 400;
  localparam int READY_DELAY_NS = 120;
  localparam int ENABLE_DELAY_NS = 80;
  localparam int WORD_WIDTH = 16;
  localparam int COUNT_WIDTH = 16;
  localparam int SYNC_STAGES = 3;

  // least times: round up, never below one cycle
  function automatic int adcs_cycles(input int t_ns);
    int c;
    c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : adcs_cycles

  localparam int CONVERT_CYC = adcs_cycles(CONVERT_TIME_NS);
  localparam int SAMPLE_CYC = adcs_cycles(SAMPLE_DELAY_NS);
  localparam int MIN_RETRIGGER_CYC = adcs_cycles(MIN_RETRIGGER_NS);
  localparam int READY_CYC = adcs_cycles(READY_DELAY_NS);
  localparam int ENABLE_CYC = adcs_cycles(ENABLE_DELAY_NS);

endpackage : adcs_pkg

// ===== hdl/adcs_sequencer.sv
// Functional notes
// - a conversion starts on the conversion clock edge chosen by edge_select.
// - the input is sampled once, when the sample interval after the trigger edge has passed.
// - the output word takes the new result exactly one conversion latency after the trigger.
// - when the word changes, data_ready drops and returns high after the ready delay.
// - a new conversion may start while one is in flight if the retrigger gap has passed.
// - a trigger sooner than the retrigger gap after the last start is ignored.
// - the output word is coded as unsigned, two's complement or offset binary.
// - data_ready starts in a configurable state, ready or not ready.
// - the overflow outputs start as positive high, negative high or both low.
// - the output word is enabled only after the enable latency from output_enable rising.
// - the output word width is configurable from one to thirty-two bits.
// - before any conversion completes the word holds a configurable initial value.
// - in the fixed-range variant the span and midpoint come from configuration.
// - in the reference variant the span is reference minus return, low end the return level.
`timescale 1ns/10ps
module adcs_sequencer #(
  parameter int WORD_WIDTH = adcs_pkg::WORD_WIDTH,
  parameter logic [31:0] INITIAL_OUTPUT_VALUE = 32'h0000_0000,
  parameter adcs_pkg::adcs_ready_t READY_INITIAL_STATE = adcs_pkg::ADCS_READY_NO,
  parameter adcs_pkg::adcs_ovf_t OVERFLOW_INITIAL_STATE = adcs_pkg::ADCS_OVF_NONE
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic conv_clk,
  input wire adcs_pkg::adcs_edge_t edge_select,
  input wire adcs_pkg::adcs_code_t coding_select,
  input wire logic use_reference,
  input wire logic signed [31:0] sample_in,
  input wire logic signed [31:0] range_span,
  input wire logic signed [31:0] range_midpoint,
  input wire logic signed [31:0] reference_level,
  input wire logic signed [31:0] reference_return,
  input wire logic output_enable,
  output logic [WORD_WIDTH-1:0] data_out,
  output logic output_enabled,
  output logic data_ready,
  output logic positive_overflow,
  output logic negative_overflow
);

  localparam int PIPE = adcs_pkg::CONVERT_CYC - 1;
  localparam int SAMP = adcs_pkg::SAMPLE_CYC;
  localparam int CW = adcs_pkg::COUNT_WIDTH;
  localparam int ENT = WORD_WIDTH + 2;
  localparam logic [CW-1:0] MIN_GAP = CW'(adcs_pkg::MIN_RETRIGGER_CYC);
  localparam logic [CW-1:0] READY_LEN = CW'(adcs_pkg::READY_CYC);
  localparam logic [CW-1:0] ENABLE_LEN = CW'(adcs_pkg::ENABLE_CYC);
  localparam logic [WORD_WIDTH-1:0] WORD_INIT = INITIAL_OUTPUT_VALUE[WORD_WIDTH-1:0];
  localparam logic [WORD_WIDTH-1:0] WORD_MSB = WORD_WIDTH'(1) << (WORD_WIDTH - 1);
  localparam logic WORD_ALL1 = 1'b1;

  // sample -> {pos_ovf, neg_ovf, raw unsigned code}
  function automatic logic [ENT-1:0] adcs_quantise(input logic signed [31:0] x,
                                                   input logic signed [31:0] lo_in,
                                                   input logic signed [32:0] sp_in);
    logic signed [71:0] lo;
    logic signed [71:0] sp;
    logic signed [71:0] d;
    logic signed [71:0] q;
    logic signed [71:0] full;
    lo = 72'(lo_in);
    sp = 72'(sp_in);
    // guards a broken reference: the quotient stays defined
    if (sp <= 0)
    begin
      sp = 72'sd1;
    end
    d = 72'(x) - lo;
    full = 72'sd1 <<< WORD_WIDTH;
    q = (d <<< WORD_WIDTH) / sp;
    if (d < 0)
    begin
      return {1'b0, 1'b1, {WORD_WIDTH{1'b0}}};
    end
    else if (q >= full)
    begin
      return {1'b1, 1'b0, {WORD_WIDTH{WORD_ALL1}}};
    end
    return {2'b00, q[WORD_WIDTH-1:0]};
  endfunction : adcs_quantise

  localparam int SYNC_W = adcs_pkg::SYNC_STAGES;
  logic [SYNC_W-1:0] sync_reg;
  logic [SYNC_W-1:0] sync_fill_reg;
  logic [PIPE-1:0] valid_reg;
  logic [ENT-1:0] data_reg [PIPE];
  logic [CW-1:0] gap_reg;
  logic [CW-1:0] ready_cnt_reg;
  logic [CW-1:0] enable_cnt_reg;
  logic [WORD_WIDTH-1:0] word_reg;
  logic [WORD_WIDTH-1:0] data_out_reg;
  logic ready_reg;
  logic pos_ovf_reg;
  logic neg_ovf_reg;
  logic enabled_reg;

  initial
  begin
    if (WORD_WIDTH < 1 || WORD_WIDTH > 32 || SAMP >= PIPE)
    begin
      $error("adcs_sequencer: width or timing out of range");
    end
  end

  // edge detect, on differing second and third stages
  wire edge_rise = sync_reg[1] & ~sync_reg[2];
  wire edge_fall = ~sync_reg[1] & sync_reg[2];
  // a pin idling high would look like a rise while the stages still hold reset zeros
  wire sync_full = sync_fill_reg[SYNC_W-1];
  wire trig_edge = sync_full &
    ((edge_select == adcs_pkg::ADCS_EDGE_RISE) ? edge_rise : edge_fall);
  wire gap_ok = (gap_reg >= MIN_GAP);
  wire start = trig_edge & gap_ok;
  // sample taken when the entry lands at the sample stage
  wire sample_take = valid_reg[SAMP-1];
  wire word_update = valid_reg[PIPE-1];
  wire [ENT-1:0] last_ent = data_reg[PIPE-1];
  // span and low end of the input range
  wire signed [32:0] span_sel = use_reference ?
    (33'(reference_level) - 33'(reference_return)) : 33'(range_span);
  wire signed [31:0] low_sel = use_reference ? reference_return :
    32'(range_midpoint - (range_span >>> 1));
  wire [ENT-1:0] quant = adcs_quantise(sample_in, low_sel, span_sel);
  wire [WORD_WIDTH-1:0] word_next = word_update ? last_ent[WORD_WIDTH-1:0] : word_reg;
  // two's complement moves the midpoint code to zero
  wire [WORD_WIDTH-1:0] coded_next = (coding_select == adcs_pkg::ADCS_CODE_TWOS) ?
    (word_next ^ WORD_MSB) : word_next;
  // enable latency
  // latency counts from the first edge that sees the enable high
  wire enabled_next = output_enable && (enable_cnt_reg >= ENABLE_LEN);
  wire [WORD_WIDTH-1:0] data_out_next = enabled_next ? coded_next : '0;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync_reg <= '0;
      sync_fill_reg <= '0;
      gap_reg <= MIN_GAP;
    end
    else
    begin
      sync_reg <= {sync_reg[SYNC_W-2:0], conv_clk};
      sync_fill_reg <= {sync_fill_reg[SYNC_W-2:0], 1'b1};
      gap_reg <= start ? CW'(1) : (gap_ok ? gap_reg : gap_reg + CW'(1));
    end
  end

  // conversions in flight move down the pipe together
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      valid_reg <= '0;
    end
    else
    begin
      valid_reg <= {valid_reg[PIPE-2:0], start};
    end
  end

  always_ff @(posedge clk)
  begin
    data_reg[0] <= '0;
    for (int i = 1; i < PIPE; i++)
    begin
      data_reg[i] <= (i == SAMP) ? quant : data_reg[i-1];
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      word_reg <= WORD_INIT;
      ready_reg <= (READY_INITIAL_STATE == adcs_pkg::ADCS_READY_YES);
      pos_ovf_reg <= (OVERFLOW_INITIAL_STATE == adcs_pkg::ADCS_OVF_POS);
      neg_ovf_reg <= (OVERFLOW_INITIAL_STATE == adcs_pkg::ADCS_OVF_NEG);
      ready_cnt_reg <= '0;
    end
    // word and overflow load in the same cycle that ready drops
    else if (word_update)
    begin
      word_reg <= word_next;
      pos_ovf_reg <= last_ent[ENT-1];
      neg_ovf_reg <= last_ent[ENT-2];
      ready_reg <= 1'b0;
      ready_cnt_reg <= READY_LEN;
    end
    else if (ready_cnt_reg != '0)
    begin
      ready_cnt_reg <= ready_cnt_reg - CW'(1);
      ready_reg <= (ready_cnt_reg == CW'(1));
    end
  end

  // enable counter saturates at the latency
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      enable_cnt_reg <= '0;
      enabled_reg <= 1'b0;
      data_out_reg <= '0;
    end
    else
    begin
      enable_cnt_reg <= !output_enable ? '0 :
        (enable_cnt_reg < ENABLE_LEN ? enable_cnt_reg + CW'(1) : enable_cnt_reg);
      enabled_reg <= enabled_next;
      data_out_reg <= data_out_next;
    end
  end

  assign data_out = data_out_reg;
  assign output_enabled = enabled_reg;
  assign data_ready = ready_reg;
  assign positive_overflow = pos_ovf_reg;
  assign negative_overflow = neg_ovf_reg;

  localparam int CONV_I = adcs_pkg::CONVERT_CYC;
  localparam int SAMP_I = adcs_pkg::SAMPLE_CYC;
  localparam int READY_I = adcs_pkg::READY_CYC;
  localparam int ENABLE_I = adcs_pkg::ENABLE_CYC;
  localparam int RETRIG_I = adcs_pkg::MIN_RETRIGGER_CYC;
  logic [CW-1:0] low_run_reg;
  logic [CW-1:0] en_run_reg;
  logic [CW-1:0] since_reg;
  logic any_done_reg;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      low_run_reg <= '0;
      en_run_reg <= '0;
      since_reg <= CW'(RETRIG_I);
      any_done_reg <= 1'b0;
    end
    else
    begin
      low_run_reg <= word_update ? CW'(1) : low_run_reg + CW'(1);
      en_run_reg <= output_enable ? en_run_reg + CW'(1) : '0;
      since_reg <= valid_reg[0] ? CW'(1) :
        (since_reg < CW'(RETRIG_I) ? since_reg + CW'(1) : since_reg);
      any_done_reg <= any_done_reg | word_update;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  trig_edge_a: assert property (start |-> ((edge_select == adcs_pkg::ADCS_EDGE_RISE) ?
    (sync_reg[1] && !sync_reg[2]) : (!sync_reg[1] && sync_reg[2])))
    else $error("start without the selected edge");
  sample_point_a: assert property (start |-> ##SAMP_I sample_take)
    else $error("sample not taken at the sample delay");
  word_latency_a: assert property (start |-> ##CONV_I (word_reg == $past(last_ent[WORD_WIDTH-1:0])))
    else $error("word not updated at the conversion latency");
  ready_drop_a: assert property (word_update |=> !data_ready)
    else $error("data ready did not drop on word change");
  ready_return_a: assert property ($rose(data_ready) |-> low_run_reg == CW'(READY_I + 1))
    else $error("data ready returned at the wrong time");
  retrig_gap_a: assert property (start |-> $past(gap_reg) >= MIN_GAP - CW'(1) && gap_ok)
    else $error("conversion started inside the retrigger gap");
  early_ignore_a: assert property (trig_edge && since_reg < CW'(RETRIG_I - 1) |=> !valid_reg[0])
    else $error("early trigger started a conversion");
  twos_code_a: assert property (enabled_next && coding_select == adcs_pkg::ADCS_CODE_TWOS
    |=> data_out[WORD_WIDTH-1] != word_reg[WORD_WIDTH-1])
    else $error("two's complement coding wrong");
  enable_lat_a: assert property ($rose(output_enabled) |-> en_run_reg == CW'(ENABLE_I + 1))
    else $error("output enabled before the enable latency");
  init_word_a: assert property (!any_done_reg |-> word_reg == WORD_INIT)
    else $error("initial word lost before first result");
  clamp_pos_a: assert property (positive_overflow && any_done_reg |-> &word_reg)
    else $error("positive overflow without clamped word");
  clamp_neg_a: assert property (negative_overflow && any_done_reg |-> word_reg == '0)
    else $error("negative overflow without clamped word");

  overlap_c: cover property (start ##[1:30] start);
  ignored_c: cover property (trig_edge && !gap_ok);
  overflow_c: cover property (word_update ##1 positive_overflow);
  ready_cycle_c: cover property ($fell(data_ready) ##[1:10] $rose(data_ready));

endmodule : adcs_sequencer

// ===== verification/adcs_far_side.sv
`timescale 1ns/10ps
module adcs_far_side (
  input wire logic clk,
  input wire logic fire,
  input wire logic signed [31:0] level,
  output logic conv_clk,
  output logic signed [31:0] sample_in
);
  int hold = 0;
  initial conv_clk = 1'b0;
  always @(posedge clk)
  begin
    if (fire)
      conv_clk <= ~conv_clk;
    hold <= fire ? 14 : (hold > 0 ? hold - 1 : 0);
  end
  // past the hold time the level is not kept, so a late read sees garbage
  assign sample_in = (hold > 0) ? level : ~level;
endmodule : adcs_far_side

// ===== verification/adc_conversion_sequencer_tb.sv
`timescale 1ns/10ps
module adc_conversion_sequencer_tb;
  localparam int RDY = adcs_pkg::READY_CYC;
  localparam int CNV = adcs_pkg::CONVERT_CYC;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic fire = 1'b0;
  logic use_reference = 1'b0;
  logic output_enable = 1'b0;
  logic conv_clk;
  adcs_pkg::adcs_edge_t edge_select = adcs_pkg::ADCS_EDGE_RISE;
  adcs_pkg::adcs_code_t coding_select = adcs_pkg::ADCS_CODE_UNSIGNED;
  logic signed [31:0] level = 32'h0000_0000;
  logic signed [31:0] sample_in;
  logic signed [31:0] span = 32'h0000_0100;
  logic signed [31:0] mid = 32'h0000_0080;
  logic signed [31:0] vref = 32'h0000_0200;
  logic signed [31:0] vret = 32'h0000_0000;
  logic [7:0] data_out;
  logic output_enabled, data_ready, positive_overflow, negative_overflow;
  int n_fail = 0;
  int comparisons = 0;
  int seed = 99821;
  int c;
  longint corner[4] = '{0, 255, 256, -1};
  always #20 clk = ~clk;
  adcs_far_side far (.clk(clk), .fire(fire), .level(level), .conv_clk(conv_clk),
    .sample_in(sample_in));
  // starts ready with positive overflow raised, so both start-up options leave their default
  adcs_sequencer #(.WORD_WIDTH(8), .INITIAL_OUTPUT_VALUE(32'h0000_005a),
    .READY_INITIAL_STATE(adcs_pkg::ADCS_READY_YES),
    .OVERFLOW_INITIAL_STATE(adcs_pkg::ADCS_OVF_POS)) uut (.clk(clk),
    .rst_b(rst_b), .conv_clk(conv_clk), .edge_select(edge_select),
    .coding_select(coding_select), .use_reference(use_reference), .sample_in(sample_in),
    .range_span(span), .range_midpoint(mid), .reference_level(vref),
    .reference_return(vret), .output_enable(output_enable), .data_out(data_out),
    .output_enabled(output_enabled), .data_ready(data_ready),
    .positive_overflow(positive_overflow), .negative_overflow(negative_overflow));
  task test_done;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task st(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask : st
  // one pin toggle; the idle cycle keeps fire from being set twice at once
  task pulse;
    fire = 1'b1;
    st(1);
    fire = 1'b0;
    st(1);
  endtask : pulse
  task lows(input int k, output int f);
    f = 0;
    repeat (k)
    begin
      st(1);
      f += int'(data_ready === 1'b0);
    end
  endtask : lows
  function automatic logic [9:0] expect_word(input longint x, input adcs_pkg::adcs_code_t cs);
    longint lo, sp, q;
    logic [9:0] r;
    lo = use_reference ? vret : mid - span / 2;
    sp = use_reference ? vref - vret : span;
    q = (x - lo) * 256 / sp;
    r = (x < lo) ? 10'h100 : (q > 255) ? 10'h2ff : {2'b00, q[7:0]};
    if (cs == adcs_pkg::ADCS_CODE_TWOS)
      r[7] = ~r[7];
    return r;
  endfunction : expect_word
  task convert(input longint x, input adcs_pkg::adcs_code_t cs);
    logic [9:0] e;
    level = 32'(x);
    coding_select = cs;
    e = expect_word(x, cs);
    if (conv_clk === (edge_select == adcs_pkg::ADCS_EDGE_RISE))
      pulse;
    pulse;
    c = 1;
    while (data_ready !== 1'b0)
    begin
      st(1);
      c++;
      if (c > 60)
      begin
        chk("ready timeout", 0, 1);
        test_done;
      end
    end
    chk("latency", 32'(c >= CNV + 1 && c <= CNV + 4), 1);
    chk("word", data_out, e[7:0]);
    chk("overflow", {positive_overflow, negative_overflow}, e[9:8]);
    lows(8, c);
    chk("ready low", c, RDY - 1);
  endtask : convert
  initial
  begin
    st(4);
    rst_b = 1'b1;
    chk("ready init", data_ready, 1);
    chk("ovf init", {positive_overflow, negative_overflow}, 2'b10);
    chk("out off", data_out, 0);
    output_enable = 1'b1;
    st(adcs_pkg::ENABLE_CYC);
    chk("enable early", output_enabled, 0);
    st(1);
    chk("enable", output_enabled, 1);
    chk("init word", data_out, 8'h5a);
    $display("startup test done");
    for (int i = 0; i < 12; i++)
      convert(corner[i % 4], adcs_pkg::adcs_code_t'(i / 4));
    use_reference = 1'b1;
    for (int i = 0; i < 3; i++)
      convert(200 + 156 * i, adcs_pkg::ADCS_CODE_UNSIGNED);
    use_reference = 1'b0;
    $display("coding test done");
    edge_select = adcs_pkg::ADCS_EDGE_FALL;
    convert(77, adcs_pkg::ADCS_CODE_OFFSET);
    pulse;
    lows(40, c);
    chk("wrong edge", c, 0);
    edge_select = adcs_pkg::ADCS_EDGE_RISE;
    $display("edge test done");
    // gaps stay below the conversion latency
    repeat (4) pulse;
    lows(45, c);
    chk("early retrigger", c, RDY);
    pulse;
    pulse;
    st(7);
    pulse;
    pulse;
    lows(45, c);
    chk("overlap", c, 2 * RDY);
    $display("retrigger test done");
    repeat (8)
      convert($random(seed) % 300, adcs_pkg::adcs_code_t'(($random(seed) & 255) % 3));
    output_enable = 1'b0;
    st(1);
    chk("disabled", data_out, 0);
    chk("disabled flag", output_enabled, 0);
    $display("random test done");
    test_done;
  end
endmodule : adc_conversion_sequencer_tb
